// file: src/nob_top.sv
// How it works
// - Without correction a page load stays busy at most 25 us.
// - With correction a page load stays busy at most 60 us.
// - Ending a sequential read makes the device ready within 7 us.
// - Program execute or lock stays busy the full 700 us unless a reset cuts it short.
// - Reset recovers in 5, 10 or 500 us by interrupted operation; host waits.
// - Reset with page zero reload stays busy at most 100 us; host waits.
// - Power-down is reached within 3 us after the frame ends.
// - Release from power-down returns to standby within 1.5 ms; host waits.
// - Block zero is never marked invalid.
// - At least 4016 of 4096 blocks are valid; bad ones stay isolated.
// - Invalid blocks read a non-all-ones marker byte.
// - Markers are permanent and untouched by erase.
// - In power-down only release and reset commands are obeyed.
module nob_top
  import nob_pkg::*;
#(
  parameter int PAGE_LOAD_CORRECTED = PAGE_LOAD_CORRECTED_CYC,
  parameter int PAGE_PROGRAM        = PAGE_PROGRAM_CYC,
  parameter int RESET_ERASE         = RESET_ERASE_CYC,
  parameter int RESET_RELOAD        = RESET_RELOAD_CYC,
  parameter int RELEASE_POWER_DOWN  = RELEASE_POWER_DOWN_CYC,
  parameter int BLOCK_ERASE         = BLOCK_ERASE_CYC,
  parameter logic [11:0] BAD_LIST [BAD_LIST_LEN] = '{12'h005, 12'h0a3, 12'h1f0, 12'h3ff,
                                                     12'h000, 12'h000, 12'h000, 12'h000}
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              link_clk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  input  wire nob_pkg::nob_cfg_t cfg,
  input  wire logic              array_fail,
  input  wire logic [1:0]        ecc_result,
  input  wire logic              mark_rd_valid,
  input  wire logic [11:0]       mark_rd_block,
  output nob_pkg::nob_stat_t     stat_q,
  output logic                   cmd_done_q,
  output logic                   cmd_ignored_q,
  output logic [7:0]             mark_byte_q,
  output logic                   mark_valid_q
);

  // ==========================================================
  // Link front end and crossings.
  logic [7:0] link_byte;
  logic       link_tgl;
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       tgl_s3_q;
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic       cs_s3_q;
  logic       byte_evt;
  logic       frame_end;

  nob_link u_link (
    .link_clk   (link_clk),
    .rst_n      (rst_n),
    .cs_n       (cs_n),
    .mosi       (mosi),
    .byte_q     (link_byte),
    .byte_tgl_q (link_tgl)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
    end
    else
    begin
      tgl_s1_q <= link_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
    end
  end

  assign byte_evt  = tgl_s2_q ^ tgl_s3_q;
  assign frame_end = cs_s2_q & ~cs_s3_q;

  // ==========================================================
  // Frame opcode capture; the first byte of each frame is the command.
  logic [7:0] opcode_q;
  logic       got_op_q;
  logic       reset_armed_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opcode_q <= 8'h00;
      got_op_q <= 1'b0;
    end
    else if (frame_end)
    begin
      got_op_q <= 1'b0;
    end
    else if (byte_evt && !got_op_q)
    begin
      opcode_q <= link_byte;
      got_op_q <= 1'b1;
    end
  end

  // ==========================================================
  // Operation sequencer.
  typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_PD_ENTER, ST_PD, ST_PD_EXIT} nob_state_t;

  nob_state_t       state_q;
  nob_opk_t         opk_q;
  logic [CNT_W-1:0] cnt_q;
  logic             cmd_valid;
  logic             is_reset;
  logic             allowed;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  function automatic logic [CNT_W-1:0] reset_time(input nob_opk_t k, input logic reload);
    if (reload)
      reset_time = cyc(RESET_RELOAD);
    else
    begin
      case (k)
        OPK_PROGRAM: reset_time = cyc(RESET_PROGRAM_CYC);
        OPK_ERASE:   reset_time = cyc(RESET_ERASE);
        default:     reset_time = cyc(RESET_READ_CYC);
      endcase
    end
  endfunction

  assign cmd_valid = frame_end && got_op_q;
  assign is_reset  = (opcode_q == OP_RESET) || (opcode_q == OP_RESET_DEVICE && reset_armed_q);

  always_comb
  begin
    case (state_q)
      ST_IDLE:     allowed = 1'b1;
      ST_BUSY:     allowed = is_reset || opcode_q == OP_READ_STATUS || opcode_q == OP_RESET_ENABLE;
      ST_PD:       allowed = is_reset || opcode_q == OP_RELEASE_PD || opcode_q == OP_RESET_ENABLE;
      default:     allowed = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_armed_q <= 1'b0;
    else if (cmd_valid)
      reset_armed_q <= allowed && opcode_q == OP_RESET_ENABLE;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      opk_q   <= OPK_NONE;
      cnt_q   <= '0;
    end
    else if (cmd_valid && allowed && is_reset)
    begin
      state_q <= ST_BUSY;
      opk_q   <= OPK_NONE;
      cnt_q   <= reset_time(state_q == ST_BUSY ? opk_q : OPK_NONE, cfg.reload_en);
    end
    else if (cmd_valid && allowed && state_q == ST_PD && opcode_q == OP_RELEASE_PD)
    begin
      state_q <= ST_PD_EXIT;
      cnt_q   <= cyc(RELEASE_POWER_DOWN);
    end
    else if (cmd_valid && allowed && state_q == ST_IDLE)
    begin
      case (opcode_q)
        OP_PAGE_LOAD:
        begin
          state_q <= ST_BUSY;
          opk_q   <= OPK_READ;
          cnt_q   <= cfg.ecc_en ? cyc(PAGE_LOAD_CORRECTED) : cyc(PAGE_LOAD_PLAIN_CYC);
        end
        OP_SEQ_READ:
        begin
          if (cfg.seq_mode)
          begin
            state_q <= ST_BUSY;
            opk_q   <= OPK_READ;
            cnt_q   <= cyc(SEQ_READ_STOP_CYC);
          end
        end
        OP_PROGRAM_EXEC, OP_OTP_LOCK:
        begin
          state_q <= ST_BUSY;
          opk_q   <= OPK_PROGRAM;
          cnt_q   <= cyc(PAGE_PROGRAM);
        end
        OP_BLOCK_ERASE:
        begin
          state_q <= ST_BUSY;
          opk_q   <= OPK_ERASE;
          cnt_q   <= cyc(BLOCK_ERASE);
        end
        OP_POWER_DOWN:
        begin
          state_q <= ST_PD_ENTER;
          cnt_q   <= cyc(POWER_DOWN_ENTRY_CYC);
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
    else
    begin
      case (state_q)
        ST_BUSY, ST_PD_ENTER, ST_PD_EXIT:
        begin
          if (cnt_q == '0)
          begin
            state_q <= (state_q == ST_PD_ENTER) ? ST_PD : ST_IDLE;
            opk_q   <= OPK_NONE;
          end
          else
            cnt_q <= cnt_q - CNT_W'(1);
        end
        ST_IDLE, ST_PD:
        begin
          cnt_q <= '0;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags and command strobes.
  logic op_end;

  assign op_end = state_q == ST_BUSY && cnt_q == '0 && !(cmd_valid && allowed && is_reset);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q        <= '0;
      cmd_done_q    <= 1'b0;
      cmd_ignored_q <= 1'b0;
    end
    else
    begin
      stat_q.busy       <= state_q inside {ST_BUSY, ST_PD_ENTER, ST_PD_EXIT};
      stat_q.power_down <= state_q == ST_PD || state_q == ST_PD_ENTER;
      cmd_done_q        <= op_end;
      cmd_ignored_q     <= cmd_valid && !allowed;
      if (op_end && opk_q == OPK_PROGRAM)
        stat_q.p_fail <= array_fail;
      else if (cmd_valid && allowed && state_q == ST_IDLE && opcode_q == OP_PROGRAM_EXEC)
        stat_q.p_fail <= 1'b0;
      if (op_end && opk_q == OPK_ERASE)
        stat_q.e_fail <= array_fail;
      else if (cmd_valid && allowed && state_q == ST_IDLE && opcode_q == OP_BLOCK_ERASE)
        stat_q.e_fail <= 1'b0;
      if (op_end && opk_q == OPK_READ)
        stat_q.ecc_stat <= ecc_result;
    end
  end

  // ==========================================================
  // Factory invalid-block markers, held in fixed logic so erase never alters them.
  function automatic logic block_is_bad(input logic [11:0] blk);
    block_is_bad = 1'b0;
    for (int i = 0; i < BAD_LIST_LEN; i++)
    begin
      if (BAD_LIST[i] == blk && blk != 12'h000)
        block_is_bad = 1'b1;
    end
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mark_byte_q  <= MARK_GOOD;
      mark_valid_q <= 1'b0;
    end
    else
    begin
      mark_valid_q <= mark_rd_valid;
      if (mark_rd_valid)
        mark_byte_q <= block_is_bad(mark_rd_block) ? MARK_BAD : MARK_GOOD;
    end
  end

endmodule

// file: src/nob_pkg.sv
package nob_pkg;

  // ==========================================================
  // Clock and operation times.
  localparam int SYS_CLK_MHZ                 = 125;
  localparam int PAGE_LOAD_TIME_PLAIN_US     = 25;
  localparam int PAGE_LOAD_TIME_CORRECTED_US = 60;
  localparam int SEQ_READ_STOP_TIME_US       = 7;
  localparam int PAGE_PROGRAM_TIME_US        = 700;
  localparam int PAGE_PROGRAM_TYP_US         = 250;
  localparam int RESET_READ_US               = 5;
  localparam int RESET_PROGRAM_US            = 10;
  localparam int RESET_ERASE_US              = 500;
  localparam int RESET_RELOAD_RECOVERY_US    = 100;
  localparam int POWER_DOWN_ENTRY_TIME_US    = 3;
  localparam int RELEASE_POWER_DOWN_NS       = 1500000;
  localparam int BLOCK_ERASE_US              = 10000;

  localparam int PAGE_LOAD_PLAIN_CYC     = PAGE_LOAD_TIME_PLAIN_US * SYS_CLK_MHZ;
  localparam int PAGE_LOAD_CORRECTED_CYC = PAGE_LOAD_TIME_CORRECTED_US * SYS_CLK_MHZ;
  localparam int SEQ_READ_STOP_CYC       = SEQ_READ_STOP_TIME_US * SYS_CLK_MHZ;
  localparam int PAGE_PROGRAM_CYC        = PAGE_PROGRAM_TIME_US * SYS_CLK_MHZ;
  localparam int RESET_READ_CYC          = RESET_READ_US * SYS_CLK_MHZ;
  localparam int RESET_PROGRAM_CYC       = RESET_PROGRAM_US * SYS_CLK_MHZ;
  localparam int RESET_ERASE_CYC         = RESET_ERASE_US * SYS_CLK_MHZ;
  localparam int RESET_RELOAD_CYC        = RESET_RELOAD_RECOVERY_US * SYS_CLK_MHZ;
  localparam int POWER_DOWN_ENTRY_CYC    = POWER_DOWN_ENTRY_TIME_US * SYS_CLK_MHZ;
  localparam int RELEASE_POWER_DOWN_CYC  = RELEASE_POWER_DOWN_NS / 1000 * SYS_CLK_MHZ;
  localparam int BLOCK_ERASE_CYC         = BLOCK_ERASE_US * SYS_CLK_MHZ;

  // ==========================================================
  // Array geometry and invalid-block marking.
  localparam int         BLOCK_COUNT      = 4096;
  localparam int         MIN_VALID_BLOCKS = 4016;
  localparam int         BAD_LIST_LEN     = 8;
  localparam logic [7:0] MARK_GOOD        = 8'hff;
  localparam logic [7:0] MARK_BAD         = 8'h00;
  localparam int         PARTIAL_PROGRAM_LIMIT = 4;

  // ==========================================================
  // Command opcodes.
  localparam logic [7:0] OP_PAGE_LOAD    = 8'h13;
  localparam logic [7:0] OP_SEQ_READ     = 8'h03;
  localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
  localparam logic [7:0] OP_OTP_LOCK     = 8'h1f;
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'hd8;
  localparam logic [7:0] OP_READ_STATUS  = 8'h0f;
  localparam logic [7:0] OP_RESET        = 8'hff;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  localparam logic [7:0] OP_POWER_DOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE_PD   = 8'hab;

  localparam int CNT_W = 24;

  typedef enum logic [1:0] {OPK_NONE, OPK_READ, OPK_PROGRAM, OPK_ERASE} nob_opk_t;

  typedef struct packed {
    logic ecc_en;
    logic reload_en;
    logic seq_mode;
  } nob_cfg_t;

  typedef struct packed {
    logic       busy;
    logic       power_down;
    logic       p_fail;
    logic       e_fail;
    logic [1:0] ecc_stat;
  } nob_stat_t;

endpackage

// file: src/nob_link.sv
module nob_link
  import nob_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic [7:0]      byte_q,
  output logic            byte_tgl_q
);

  // ==========================================================
  // Shift register on the link clock; cleared while the frame is closed.
  logic       frame_rst_n;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;

  assign frame_rst_n = rst_n & ~cs_n;

  always_ff @(posedge link_clk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], mosi};
    end
  end

  // Whole byte is held and announced by a toggle for the system domain.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_q     <= 8'h00;
      byte_tgl_q <= 1'b0;
    end
    else if (!cs_n && bit_cnt_q == 3'h7)
    begin
      byte_q     <= {shift_q, mosi};
      byte_tgl_q <= ~byte_tgl_q;
    end
  end

endmodule

// file: sim/nob_top_assertions.sv
// ==========================================================
// Port checker for the operation sequencer.
module nob_chk
  import nob_pkg::*;
#(
  parameter int PAGE_LOAD_CORRECTED = PAGE_LOAD_CORRECTED_CYC,
  parameter int PAGE_PROGRAM        = PAGE_PROGRAM_CYC,
  parameter int BLOCK_ERASE         = BLOCK_ERASE_CYC
)
(
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire nob_pkg::nob_stat_t stat_q,
  input wire logic               cmd_done_q,
  input wire logic               cmd_ignored_q,
  input wire logic               mark_rd_valid,
  input wire logic [11:0]        mark_rd_block,
  input wire logic [7:0]         mark_byte_q,
  input wire logic               mark_valid_q
);
  localparam int MAXB = PAGE_LOAD_CORRECTED + PAGE_PROGRAM + BLOCK_ERASE + 8;
  logic [31:0] busy_cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= stat_q.busy ? busy_cnt_q + 32'h1 : '0;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_mark_answer: assert property (mark_rd_valid |=> mark_valid_q)
    else $error("marker answer missing");
  chk_mark_quiet: assert property (!mark_rd_valid |=> !mark_valid_q)
    else $error("marker answer without request");
  chk_block_zero: assert property (mark_rd_valid && mark_rd_block == 12'h000 |=> mark_byte_q == 8'hff)
    else $error("block zero reported invalid");
  chk_bad_marker: assert property (mark_rd_valid && mark_rd_block == 12'h005 |=> mark_byte_q != 8'hff)
    else $error("factory bad block reads all ones");
  chk_done_after_busy: assert property (cmd_done_q |-> $past(stat_q.busy) || $past(stat_q.busy, 2))
    else $error("done pulse without busy interval");
  chk_done_single: assert property (cmd_done_q |=> !cmd_done_q)
    else $error("done pulse longer than one cycle");
  chk_busy_bounded: assert property (busy_cnt_q <= MAXB)
    else $error("busy interval too long");
  chk_ignored_idle: assert property (cmd_ignored_q && !stat_q.busy |=> !stat_q.busy [*3])
    else $error("refused command started an operation");
  chk_pfail_at_end: assert property ($rose(stat_q.p_fail) |-> cmd_done_q || $past(cmd_done_q))
    else $error("program fail flag set outside operation end");
  chk_ecc_at_end: assert property ($changed(stat_q.ecc_stat) |-> stat_q.busy || $past(stat_q.busy))
    else $error("correction status changed while idle");
endmodule

bind nob_top nob_chk #(.PAGE_LOAD_CORRECTED(PAGE_LOAD_CORRECTED), .PAGE_PROGRAM(PAGE_PROGRAM),
                       .BLOCK_ERASE(BLOCK_ERASE)) u_chk (
  .sys_clk       (sys_clk),
  .rst_n         (rst_n),
  .stat_q        (stat_q),
  .cmd_done_q    (cmd_done_q),
  .cmd_ignored_q (cmd_ignored_q),
  .mark_rd_valid (mark_rd_valid),
  .mark_rd_block (mark_rd_block),
  .mark_byte_q   (mark_byte_q),
  .mark_valid_q  (mark_valid_q)
);

// file: sim/nob_host.sv
// ==========================================================
// Host side of the serial link; the link clock runs only in frames.
module nob_host (
  output logic link_clk,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    link_clk = 1'b0;
    cs_n     = 1'b1;
    mosi     = 1'b0;
  end

  task automatic frame(input logic [7:0] b);
    cs_n = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = b[i];
      #32;
      link_clk = 1'b1;
      #32;
      link_clk = 1'b0;
    end
    #20;
    cs_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask
endmodule

// file: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nob_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         link_clk;
  wire         cs_n;
  wire         mosi;
  nob_cfg_t    cfg = '0;
  logic        array_fail = 1'b0;
  logic [1:0]  ecc_result = 2'h0;
  logic        mark_rd_valid = 1'b0;
  logic [11:0] mark_rd_block = 12'h000;
  nob_stat_t   stat_q;
  logic        cmd_done_q;
  logic        cmd_ignored_q;
  logic [7:0]  mark_byte_q;
  logic        mark_valid_q;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          since_cs = 0;
  logic        saw_done = 1'b0;
  logic        saw_ign = 1'b0;

  nob_host u_host (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi));

  nob_top #(.PAGE_PROGRAM(2000), .RESET_ERASE(10), .RESET_RELOAD(10),
            .RELEASE_POWER_DOWN(20), .BLOCK_ERASE(2000)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .cs_n(cs_n), .mosi(mosi), .cfg(cfg),
    .array_fail(array_fail), .ecc_result(ecc_result), .mark_rd_valid(mark_rd_valid),
    .mark_rd_block(mark_rd_block), .stat_q(stat_q), .cmd_done_q(cmd_done_q),
    .cmd_ignored_q(cmd_ignored_q), .mark_byte_q(mark_byte_q), .mark_valid_q(mark_valid_q));

  // ==========================================================
  // Clock, monitors and watchdog.
  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cs_n === 1'b0)
      since_cs = 0;
    else
      since_cs++;
    if (cmd_done_q === 1'b1)
      saw_done = 1'b1;
    if (cmd_ignored_q === 1'b1)
      saw_ign = 1'b1;
    if (cyc == 60000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task stop_test();
    $display("Checks %0d, errors %0d.", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task op(input logic [7:0] code, input int n);
    int   c;
    logic seen;
    c = 0;
    seen = 1'b0;
    saw_done = 1'b0;
    u_host.frame(code);
    while ((!seen || stat_q.busy !== 1'b0 || c < 8) && c < n + 60)
    begin
      @(posedge sys_clk);
      #1;
      c++;
      if (stat_q.busy === 1'b1)
        seen = 1'b1;
    end
    n_tests++;
    if (since_cs < n || since_cs > n + 10)
    begin
      n_errors++;
      $display("CHECK FAILED busy cycles expected %0d seen %0d", n, since_cs);
    end
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios.
  task t_reads();
    ecc_result = 2'h2;
    op(OP_PAGE_LOAD, PAGE_LOAD_PLAIN_CYC);
    chk("done", 1, saw_done);
    chk("ecc status", 2, stat_q.ecc_stat);
    cfg.ecc_en = 1'b1;
    op(OP_PAGE_LOAD, PAGE_LOAD_CORRECTED_CYC);
    cfg.seq_mode = 1'b1;
    op(OP_SEQ_READ, SEQ_READ_STOP_CYC);
  endtask

  task t_program();
    array_fail = 1'b1;
    op(OP_PROGRAM_EXEC, 2000);
    chk("p_fail set", 1, stat_q.p_fail);
    array_fail = 1'b0;
    op(OP_PROGRAM_EXEC, 2000);
    chk("p_fail after relocation", 0, stat_q.p_fail);
    op(OP_OTP_LOCK, 2000);
    chk("p_fail clear", 0, stat_q.p_fail);
    array_fail = 1'b1;
    op(OP_BLOCK_ERASE, 2000);
    chk("e_fail set", 1, stat_q.e_fail);
    array_fail = 1'b0;
  endtask

  task t_reset();
    op(OP_RESET, RESET_READ_CYC);
    saw_ign = 1'b0;
    u_host.frame(OP_PROGRAM_EXEC);
    wait_cyc(8);
    u_host.frame(OP_PAGE_LOAD);
    wait_cyc(8);
    chk("refused while busy", 1, saw_ign);
    op(OP_RESET, RESET_PROGRAM_CYC);
    u_host.frame(OP_BLOCK_ERASE);
    wait_cyc(8);
    saw_ign = 1'b0;
    u_host.frame(OP_RESET_ENABLE);
    wait_cyc(8);
    chk("reset enable taken", 0, saw_ign);
    op(OP_RESET_DEVICE, 10);
    cfg.reload_en = 1'b1;
    op(OP_RESET, 10);
    cfg.reload_en = 1'b0;
  endtask

  task t_power_down();
    u_host.frame(OP_POWER_DOWN);
    wait_cyc(POWER_DOWN_ENTRY_CYC + 8);
    chk("power down entered", 1, stat_q.power_down);
    saw_ign = 1'b0;
    u_host.frame(OP_READ_STATUS);
    u_host.frame(OP_PAGE_LOAD);
    wait_cyc(8);
    chk("status refused", 1, saw_ign);
    chk("load refused", 0, stat_q.busy);
    u_host.frame(OP_RELEASE_PD);
    wait_cyc(28);
    chk("standby", 0, stat_q.power_down);
    chk("standby busy", 0, stat_q.busy);
  endtask

  task t_markers();
    int bad;
    bad = 0;
    for (int b = 0; b < BLOCK_COUNT; b++)
    begin
      mark_rd_block = b[11:0];
      mark_rd_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      mark_rd_valid = 1'b0;
      if (mark_byte_q !== MARK_GOOD)
        bad++;
      if (b == 0)
        chk("block zero", MARK_GOOD, mark_byte_q);
      if (b == 0)
        chk("mark valid", 1, mark_valid_q);
      if (b == 5)
        chk("bad marker", MARK_BAD, mark_byte_q);
      @(posedge sys_clk);
      #1;
    end
    chk("bad count", 4, bad);
    chk("valid floor", 1, BLOCK_COUNT - bad >= MIN_VALID_BLOCKS);
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reads();
    t_program();
    t_reset();
    t_power_down();
    t_markers();
    stop_test();
  end
endmodule
